//--- rtl/split_timer_pkg.sv
// Constants for the split auto-reload timer control block
// Assumes an 8-bit special-function-register bus on the system clock
package split_timer_pkg;
  // Register addresses on the special-function-register bus
  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  // Control register field positions
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CAPTURE_SRC = 1;
  localparam int BIT_EXT_CLOCK = 0;
  // Byte limits
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Prescaler terminal counts: divide by 12 and by 8
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV8_LAST = 4'h7;
  localparam logic [3:0] DIV_ZERO = 4'h0;
endpackage

//--- rtl/byte_counter.sv
// One 8-bit up counter with reload and carry out
// Assumes the enclosing block decides tick, carry-in and reload
`timescale 1ns/100ps
module byte_counter
  import split_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [7:0] load_value_i,
  input wire logic reload_i,
  input wire logic [7:0] reload_value_i,
  // State
  output logic [7:0] count_o,
  output logic wrap_o
);
  logic [7:0] count;
  logic [7:0] next_count;

  // Wrap when a tick meets the top value
  assign wrap_o = tick_i && (count == BYTE_MAX);
  assign count_o = count;

  // Next count: software load, then reload on wrap, then increment
  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = load_value_i;
    end else if (wrap_o && reload_i) begin
      next_count = reload_value_i;
    end else if (tick_i) begin
      next_count = count + 8'h01;
    end
  end

  // Count register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= BYTE_ZERO;
    end else begin
      count <= next_count;
    end
  end
endmodule // byte_counter

//--- rtl/split_timer.sv
// Timer three: control register, reload low byte, counters, capture
// Assumes the processor's register bus on clk_i, one cycle writes, combinational reads
`timescale 1ns/100ps
module split_timer
  import split_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_write_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Interrupt enable and request
  input wire logic timer_irq_enable_i,
  output logic timer_irq_o,
  // Clock sources and capture
  input wire logic ext_clock_i,
  input wire logic low_frequency_oscillator_i,
  input wire logic high_half_clock_select_i,
  input wire logic low_half_clock_select_i,
  // Count and reload high byte from the neighbouring registers
  input wire logic count_low_write_i,
  input wire logic count_high_write_i,
  input wire logic reload_high_write_i,
  input wire logic [7:0] count_wdata_i,
  output logic [7:0] count_low_byte_o,
  output logic [7:0] count_high_byte_o,
  output logic [7:0] timer_three_reload_high_o
);
  // ==========================================================
  // Registers
  logic [7:0] timer_three_control;
  logic [7:0] timer_three_reload_low;
  logic [7:0] timer_three_reload_high;
  logic [7:0] next_control;
  logic [7:0] next_reload_low;
  logic [7:0] next_reload_high;
  logic ctrl_write;
  logic reload_low_write;
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_overflow_irq_enable;
  logic osc_capture_enable;
  logic split_enable;
  logic run_bit;
  logic capture_source_select;
  logic ext_clock_select;

  assign high_overflow_flag = timer_three_control[BIT_HIGH_FLAG];
  assign low_overflow_flag = timer_three_control[BIT_LOW_FLAG];
  assign low_overflow_irq_enable = timer_three_control[BIT_LOW_IRQ_EN];
  assign osc_capture_enable = timer_three_control[BIT_CAPTURE_EN];
  assign split_enable = timer_three_control[BIT_SPLIT];
  assign run_bit = timer_three_control[BIT_RUN];
  assign capture_source_select = timer_three_control[BIT_CAPTURE_SRC];
  assign ext_clock_select = timer_three_control[BIT_EXT_CLOCK];

  // Address decode
  always_comb begin
    ctrl_write = 1'b0;
    reload_low_write = 1'b0;
    if (sfr_write_i && sfr_addr_i == ADDR_CONTROL) begin
      ctrl_write = 1'b1;
    end else if (sfr_write_i && sfr_addr_i == ADDR_RELOAD_LOW) begin
      reload_low_write = 1'b1;
    end
  end

  // ==========================================================
  // Input synchronisers: three stages, change taken when 2 and 3 agree
  logic [2:0] ext_sync;
  logic [2:0] osc_sync;
  logic ext_level;
  logic osc_level;
  logic next_ext_level;
  logic next_osc_level;

  always_comb begin
    next_ext_level = (ext_sync[1] == ext_sync[2]) ? ext_sync[2] : ext_level;
    next_osc_level = (osc_sync[1] == osc_sync[2]) ? osc_sync[2] : osc_level;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync <= 3'h0;
      osc_sync <= 3'h0;
      ext_level <= 1'b0;
      osc_level <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_clock_i};
      osc_sync <= {osc_sync[1:0], low_frequency_oscillator_i};
      ext_level <= next_ext_level;
      osc_level <= next_osc_level;
    end
  end

  // ==========================================================
  // Prescalers
  logic [3:0] div12_count;
  logic [3:0] div8_count;
  logic [3:0] next_div12;
  logic [3:0] next_div8;
  logic ext_rise;
  logic osc_fall;
  logic div12_tick;
  logic div8_tick;
  logic divided_tick;

  assign ext_rise = next_ext_level && !ext_level;
  assign osc_fall = !next_osc_level && osc_level;
  assign div12_tick = (div12_count == DIV12_LAST);
  assign div8_tick = ext_rise && (div8_count == DIV8_LAST);
  assign divided_tick = ext_clock_select ? div8_tick : div12_tick;

  always_comb begin
    next_div12 = div12_tick ? DIV_ZERO : div12_count + 4'h1;
    next_div8 = div8_count;
    if (div8_tick) begin
      next_div8 = DIV_ZERO;
    end else if (ext_rise) begin
      next_div8 = div8_count + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div12_count <= DIV_ZERO;
      div8_count <= DIV_ZERO;
    end else begin
      div12_count <= next_div12;
      div8_count <= next_div8;
    end
  end

  // ==========================================================
  // Counters
  logic low_clock;
  logic high_clock;
  logic low_tick;
  logic high_tick;
  logic low_wrap;
  logic high_wrap;
  logic [7:0] count_low;
  logic [7:0] count_high;

  // Per-half clock choice
  assign low_clock = low_half_clock_select_i ? 1'b1 : divided_tick;
  assign high_clock = high_half_clock_select_i ? 1'b1 : divided_tick;
  // Low byte free-runs in split mode
  assign low_tick = low_clock && (run_bit || split_enable);
  // High byte: own clock when split, carry from low otherwise
  assign high_tick = split_enable ? (high_clock && run_bit) : low_wrap;

  byte_counter low_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(low_tick),
    .load_i(count_low_write_i),
    .load_value_i(count_wdata_i),
    .reload_i(split_enable || (count_high == BYTE_MAX)),
    .reload_value_i(timer_three_reload_low),
    .count_o(count_low),
    .wrap_o(low_wrap)
  );

  byte_counter high_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(high_tick),
    .load_i(count_high_write_i),
    .load_value_i(count_wdata_i),
    .reload_i(1'b1),
    .reload_value_i(timer_three_reload_high),
    .count_o(count_high),
    .wrap_o(high_wrap)
  );

  // ==========================================================
  // Control and reload next values
  logic capture_event;
  assign capture_event = osc_capture_enable && capture_source_select && osc_fall;

  always_comb begin
    next_control = timer_three_control;
    next_reload_low = timer_three_reload_low;
    next_reload_high = timer_three_reload_high;
    if (ctrl_write) begin
      next_control = sfr_wdata_i;
    end
    // Hardware sets win over software clears
    if (high_wrap) begin
      next_control[BIT_HIGH_FLAG] = 1'b1;
    end
    if (low_wrap) begin
      next_control[BIT_LOW_FLAG] = 1'b1;
    end
    if (reload_low_write) begin
      next_reload_low = sfr_wdata_i;
    end
    if (reload_high_write_i) begin
      next_reload_high = count_wdata_i;
    end
    if (capture_event) begin
      next_reload_low = count_low;
      next_reload_high = count_high;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_three_control <= CONTROL_RESET;
      timer_three_reload_low <= RELOAD_RESET;
      timer_three_reload_high <= RELOAD_RESET;
    end else begin
      timer_three_control <= next_control;
      timer_three_reload_low <= next_reload_low;
      timer_three_reload_high <= next_reload_high;
    end
  end

  // ==========================================================
  // Capture interrupt latch
  logic capture_pending;
  logic next_capture_pending;
  always_comb begin
    next_capture_pending = capture_pending;
    if (capture_event) begin
      next_capture_pending = 1'b1;
    end else if (ctrl_write) begin
      next_capture_pending = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_pending <= 1'b0;
    end else begin
      capture_pending <= next_capture_pending;
    end
  end

  // Interrupt request level
  assign timer_irq_o = timer_irq_enable_i && (high_overflow_flag
    || (low_overflow_irq_enable && low_overflow_flag) || capture_pending);

  // ==========================================================
  // Read data
  always_comb begin
    sfr_rdata_o = BYTE_ZERO;
    if (sfr_addr_i == ADDR_CONTROL) begin
      sfr_rdata_o = timer_three_control;
    end else if (sfr_addr_i == ADDR_RELOAD_LOW) begin
      sfr_rdata_o = timer_three_reload_low;
    end
  end

  assign count_low_byte_o = count_low;
  assign count_high_byte_o = count_high;
  assign timer_three_reload_high_o = timer_three_reload_high;
endmodule // split_timer

//--- sim/split_timer_sva.sv
// Checker for the split timer control block
// Assumes the bench idles the bus address on the control register
`timescale 1ns/100ps
module split_timer_sva
  import split_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_write_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // Interrupt
  input wire logic timer_irq_enable_i,
  input wire logic timer_irq_o,
  // Clock selects and counts
  input wire logic high_half_clock_select_i,
  input wire logic low_half_clock_select_i,
  input wire logic count_low_write_i,
  input wire logic count_high_write_i,
  input wire logic [7:0] count_low_byte_o,
  input wire logic [7:0] count_high_byte_o,
  input wire logic [7:0] timer_three_reload_high_o
);
  // ========
  // Helpers
  logic ctl;
  logic idle;
  assign ctl = (sfr_addr_i == ADDR_CONTROL);
  assign idle = ctl && !sfr_write_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ========
  // Assertions
  a_reset_clears: assert property (disable iff (1'b0) rst_i |=> sfr_rdata_o == 8'h00 && !timer_irq_o)
    else $error("registers not cleared by reset");
  a_flags_hold: assert property (idle ##1 ctl |->
    (sfr_rdata_o[7:6] & $past(sfr_rdata_o[7:6])) == $past(sfr_rdata_o[7:6])) else $error("flag self cleared");
  a_high_wrap_flag: assert property (idle && !sfr_rdata_o[BIT_SPLIT] && sfr_rdata_o[BIT_RUN]
    && high_half_clock_select_i && low_half_clock_select_i && !count_low_write_i && !count_high_write_i
    && count_high_byte_o == BYTE_MAX && count_low_byte_o == BYTE_MAX ##1 ctl
    |-> sfr_rdata_o[BIT_HIGH_FLAG] && count_high_byte_o == $past(timer_three_reload_high_o))
    else $error("16-bit wrap wrong");
  a_low_wrap_flag: assert property (idle && sfr_rdata_o[BIT_SPLIT] && low_half_clock_select_i
    && !count_low_write_i && count_low_byte_o == BYTE_MAX ##1 ctl |-> sfr_rdata_o[BIT_LOW_FLAG])
    else $error("low flag not set");
  a_low_counts: assert property (idle && sfr_rdata_o[BIT_SPLIT] && low_half_clock_select_i
    && !count_low_write_i && count_low_byte_o != BYTE_MAX |=> count_low_byte_o == $past(count_low_byte_o) + 8'h01)
    else $error("low byte not counting");
  a_high_gated: assert property (idle && sfr_rdata_o[BIT_SPLIT] && !sfr_rdata_o[BIT_RUN]
    && !count_high_write_i |=> $stable(count_high_byte_o)) else $error("high byte ran while stopped");
  a_irq_high: assert property (ctl && sfr_rdata_o[BIT_HIGH_FLAG] && timer_irq_enable_i |-> timer_irq_o)
    else $error("no irq on high flag");
  a_irq_low: assert property (ctl && sfr_rdata_o[BIT_LOW_FLAG] && sfr_rdata_o[BIT_LOW_IRQ_EN]
    && timer_irq_enable_i |-> timer_irq_o) else $error("no irq on low flag");
  a_irq_masked: assert property (!timer_irq_enable_i |-> !timer_irq_o)
    else $error("irq while disabled");
  a_reload_low_rw: assert property (sfr_write_i && sfr_addr_i == ADDR_RELOAD_LOW ##1
    sfr_addr_i == ADDR_RELOAD_LOW |-> sfr_rdata_o == $past(sfr_wdata_i)) else $error("reload low lost");
endmodule // split_timer_sva

bind split_timer split_timer_sva u_sva (.clk_i, .rst_i, .sfr_addr_i, .sfr_write_i, .sfr_wdata_i,
  .sfr_rdata_o, .timer_irq_enable_i, .timer_irq_o, .high_half_clock_select_i, .low_half_clock_select_i,
  .count_low_write_i, .count_high_write_i, .count_low_byte_o, .count_high_byte_o, .timer_three_reload_high_o);

//--- sim/tb_top.sv
// Testbench for the split timer control block
// Assumes the design is bound to its checker
`timescale 1ns/100ps
module tb_top;
  import split_timer_pkg::*;
  logic clk_i, rst_i, sfr_write_i, timer_irq_enable_i, timer_irq_o, ext_clock_i, low_frequency_oscillator;
  logic high_sel, low_sel, clw, chw, rhw;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, count_wdata_i, cl, ch, rh;
  int err_count = 0;
  int check_count = 0;
  int n;
  split_timer u_dut (.clk_i, .rst_i, .sfr_addr_i, .sfr_write_i, .sfr_wdata_i, .sfr_rdata_o,
    .timer_irq_enable_i, .timer_irq_o, .ext_clock_i, .low_frequency_oscillator_i(low_frequency_oscillator),
    .high_half_clock_select_i(high_sel), .low_half_clock_select_i(low_sel), .count_low_write_i(clw),
    .count_high_write_i(chw), .reload_high_write_i(rhw), .count_wdata_i, .count_low_byte_o(cl),
    .count_high_byte_o(ch), .timer_three_reload_high_o(rh));
  // ========
  // Clocks: system and free running external
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    ext_clock_i = 1'b0;
    forever #110 ext_clock_i = ~ext_clock_i;
  end
  // ========
  // Tasks
  task automatic step();
    @(posedge clk_i);
    #5;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_write_i = 1'b1;
    step();
    sfr_write_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    sfr_addr_i = a;
    #1;
    check(what, sfr_rdata_o, exp);
    step();
  endtask
  task automatic load(input logic [7:0] hi, input logic [7:0] lo);
    count_wdata_i = hi;
    chw = 1'b1;
    step();
    chw = 1'b0;
    count_wdata_i = lo;
    clw = 1'b1;
    step();
    clw = 1'b0;
  endtask
  task automatic wait_flag(input int b);
    for (int i = 0; i < 300 && sfr_rdata_o[b] !== 1'b1; i++) step();
  endtask
  task automatic gap();
    logic [7:0] c;
    c = cl;
    for (n = 0; n < 100 && cl === c; n++) step();
  endtask
  task automatic capture(input logic [7:0] ctrl);
    wr(ADDR_CONTROL, ctrl);
    low_frequency_oscillator = 1'b1;
    repeat (6) step();
    low_frequency_oscillator = 1'b0;
    repeat (6) step();
  endtask
  task automatic stop_test();
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ========
  // Watchdog
  initial begin
    #500000;
    err_count++;
    stop_test();
  end
  // ========
  // Main sequence
  initial begin
    {rst_i, high_sel, low_sel} = 3'b111;
    {sfr_write_i, timer_irq_enable_i, low_frequency_oscillator, clw, chw, rhw} = 6'h00;
    {sfr_wdata_i, count_wdata_i} = 16'h0000;
    sfr_addr_i = ADDR_CONTROL;
    repeat (12) step();
    rst_i = 1'b0;
    rd(ADDR_CONTROL, CONTROL_RESET, "control reset");
    rd(ADDR_RELOAD_LOW, RELOAD_RESET, "reload reset");
    wr(ADDR_RELOAD_LOW, 8'ha5);
    rd(ADDR_RELOAD_LOW, 8'ha5, "reload rw");
    wr(8'h93, 8'h5a);
    rd(8'h93, 8'h00, "unmapped");
    rd(ADDR_RELOAD_LOW, 8'ha5, "reload kept");
    // 16-bit wrap and reload
    wr(ADDR_RELOAD_LOW, 8'h34);
    count_wdata_i = 8'h12;
    rhw = 1'b1;
    step();
    rhw = 1'b0;
    load(8'hff, 8'hfd);
    timer_irq_enable_i = 1'b1;
    wr(ADDR_CONTROL, 8'h04);
    wait_flag(BIT_HIGH_FLAG);
    check("high reload", ch, 8'h12);
    check("low reload", 8'(cl - 8'h34) < 8'h02, 8'h01);
    check("irq high", timer_irq_o, 1'b1);
    repeat (5) step();
    rd(ADDR_CONTROL, 8'hc4, "flag held");
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h00, "flag cleared");
    // Same-cycle clear and low wrap in split mode
    wr(ADDR_CONTROL, 8'h08);
    count_wdata_i = 8'hf0;
    clw = 1'b1;
    step();
    clw = 1'b0;
    repeat (15) step();
    wr(ADDR_CONTROL, 8'h08);
    rd(ADDR_CONTROL, 8'h48, "set wins");
    // Split low wrap with high byte stopped
    wr(ADDR_CONTROL, 8'h28);
    load(8'h50, 8'hfd);
    wait_flag(BIT_LOW_FLAG);
    check("high stopped", ch, 8'h50);
    check("low reload", 8'(cl - 8'h34) < 8'h02, 8'h01);
    check("irq low", timer_irq_o, 1'b1);
    check("high flag", sfr_rdata_o[BIT_HIGH_FLAG], 1'b0);
    // Divided clocks
    low_sel = 1'b0;
    wr(ADDR_CONTROL, 8'h08);
    gap();
    gap();
    check("div12 gap", 8'(n), 8'd12);
    wr(ADDR_CONTROL, 8'h09);
    gap();
    gap();
    check("ext gap", n == 35 || n == 36, 8'h01);
    low_sel = 1'b1;
    // Capture: reserved source then oscillator edge, counters stopped first
    wr(ADDR_CONTROL, 8'h00);
    load(8'hab, 8'hcd);
    capture(8'h10);
    check("no capture", rh, 8'h12);
    check("no capture irq", timer_irq_o, 1'b0);
    capture(8'h12);
    check("capture high", rh, 8'hab);
    check("capture irq", timer_irq_o, 1'b1);
    rd(ADDR_RELOAD_LOW, 8'hcd, "capture low");
    stop_test();
  end
endmodule // tb_top
